// >>> sfe_defs.vh
// Constants shared by the switch forwarding engine
`ifndef SFE_DEFS_VH
`define SFE_DEFS_VH
`define SFE_NPORT 5
`define SFE_HOST_IDX 4
`define SFE_NET_MASK 5'h0f
`define SFE_HOST_MASK 5'h10
`define SFE_ALL_NET 4'hf
`define SFE_TAG_NORMAL_BIT 7
`define SFE_TAG_FORCE_BIT 6
`define SFE_TAG_QUEUE_MSB 5
`define SFE_TAG_QUEUE_LSB 4
`define SFE_IP_VER4 4'h4
`define SFE_IP_PROTO_IGMP 8'h02
`define SFE_MLD_HOP 8'h01
`define SFE_NH_HBH 8'h00
`define SFE_NH_ICMP 8'h01
`define SFE_NH_ICMP6 8'h3a
`define SFE_NH_ROUTE 8'h2b
`define SFE_NH_FRAG 8'h2c
`define SFE_NH_ESP 8'h32
`define SFE_NH_AH 8'h33
`define SFE_NH_DEST 8'h3c
`define SFE_VLAN_ENTRIES 128
`define SFE_NULL_VID 12'h000
`endif

// >>> sfe_engine.v
// Forwarding decision engine: tail tag, snooping traps, mirroring, VLAN and MAC lookup
`timescale 1ns/100ps
`include "sfe_defs.vh"

// Functional notes
// - Tail tag handled only on host uplink port and only while tail tag enabled.
// - Uplink tag frames carry one byte between data and FCS naming the port.
// - Host tag low nibble one-hot selects port 1..4, all-ones all ports, zero reserved.
// - Host tag upper values 0..3 select egress queue 0..3 at destination.
// - Upper tag bits 01xx force delivery to the low nibble ports despite VLAN checks; bad frames are still dropped.
// - Tag bit 7 set ignores bits 6..0 and uses normal address lookup.
// - Frames to host carry ingress network port in the two lowest tag bits.
// - IGMP snooping traps IPv4 version 4 protocol 2 packets to the host only.
// - MLD snooping traps IPv6 multicast hop limit 1 with next header 1 or 58.
// - MLD option also traps next header 43, 44, 50, 51 or 60.
// - Receive-mirror port traffic also copied to sniffer; bad frames optionally.
// - Traffic leaving a transmit-mirror port also copied to the sniffer port.
// - With AND set, copy only if received on rx-mirror and sent to tx-mirror.
// - Any ports may be rx or tx mirror sources, one port the sniffer.
// - 128-entry VLAN table maps a valid VID to a 7-bit filter id.
// - In VLAN mode untagged or null-VID frames use the port default VLAN.
// - In VLAN mode an invalid VID drops the frame unless forced, and skips learning.
// - Static miss: dynamic hit sends to its port, else flood VLAN members.
// - Static hit with flag clear or filter id match uses static port mask.
// - Static hit, flag set, filter id mismatch falls back to dynamic or flood.
// - Unseen filter id plus source learned; existing entry gets its time refreshed.
// - Per-port enables for ingress filtering and discard of non-default VID.
module sfe_engine #(
    parameter NPORT = `SFE_NPORT,
    parameter VT_ENTRIES = `SFE_VLAN_ENTRIES
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Global configuration
    input wire tail_tag_en,
    input wire igmp_snoop_en,
    input wire mld_snoop_en,
    input wire mld_option,
    input wire vlan_en,
    input wire mirror_and,
    input wire sniff_bad_en,
    // Per-port configuration, bit 4 is the host uplink
    input wire [4:0] rx_sniff,
    input wire [4:0] tx_sniff,
    input wire [4:0] sniffer_port,
    input wire [4:0] ingress_filter_en,
    input wire [4:0] discard_non_port_default_vlan,
    input wire [59:0] port_default_vlan,
    // VLAN table write port
    input wire vt_wr_en,
    input wire [6:0] vt_wr_idx,
    input wire vt_wr_valid,
    input wire [11:0] vt_wr_vid,
    input wire [6:0] vt_wr_filter_id,
    input wire [4:0] vt_wr_members,
    // Packet descriptor from the parser
    input wire pkt_valid,
    input wire [2:0] pkt_port,
    input wire pkt_bad,
    input wire [7:0] pkt_tail_tag,
    input wire pkt_vlan_tagged,
    input wire [11:0] pkt_vid,
    input wire pkt_is_ipv4,
    input wire [3:0] pkt_ip_ver,
    input wire [7:0] pkt_ip_proto,
    input wire pkt_is_ipv6_mcast,
    input wire [7:0] pkt_hop_limit,
    input wire [7:0] pkt_next_hdr,
    input wire [7:0] pkt_hbh_next_hdr,
    output reg pkt_ready,
    // MAC table lookup handshake
    output reg lk_req,
    output reg [6:0] lk_filter_id,
    input wire lk_ack,
    input wire lk_static_hit,
    input wire lk_static_use_fid,
    input wire [6:0] lk_static_filter_id,
    input wire [4:0] lk_static_ports,
    input wire lk_dyn_hit,
    input wire [2:0] lk_dyn_port,
    input wire lk_sa_hit,
    // Forwarding result
    output reg fwd_valid,
    output reg [4:0] fwd_ports,
    output reg fwd_queue_set,
    output reg [1:0] fwd_queue,
    output reg fwd_strip_tag,
    output reg fwd_insert_tag,
    output reg [7:0] fwd_host_tag,
    // Learning requests
    output reg learn_insert,
    output reg learn_refresh,
    output reg [6:0] learn_filter_id
);

    localparam S_IDLE = 2'b00;
    localparam S_VLAN = 2'b01;
    localparam S_WAIT = 2'b10;

    reg [1:0] state_r;
    reg [2:0] port_r;
    reg bad_r;
    reg [7:0] tag_r;
    reg [11:0] vid_r;
    reg [11:0] port_default_vlan_r;
    reg trap_r;
    reg tag_mode_r;
    reg vlan_ok_r;
    reg [4:0] members_r;
    reg [4:0] ing_mask_r;

    // VLAN table storage
    reg vt_valid_r [0:VT_ENTRIES-1];
    reg [11:0] vt_vid_r [0:VT_ENTRIES-1];
    reg [6:0] vt_fid_r [0:VT_ENTRIES-1];
    reg [4:0] vt_mem_r [0:VT_ENTRIES-1];

    integer i, j, k;

    // Table write and reset of valid bits
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            for (i = 0; i < VT_ENTRIES; i = i + 1)
                vt_valid_r[i] <= 1'b0;
        end
        else if (vt_wr_en)
        begin
            vt_valid_r[vt_wr_idx] <= vt_wr_valid;
            vt_vid_r[vt_wr_idx] <= vt_wr_vid;
            vt_fid_r[vt_wr_idx] <= vt_wr_filter_id;
            vt_mem_r[vt_wr_idx] <= vt_wr_members;
        end
    end

    // Default VLAN of the arriving port
    reg [11:0] in_port_default_vlan;
    reg [11:0] eff_vid;
    always @*
    begin
        in_port_default_vlan = port_default_vlan[pkt_port*12 +: 12];
        if (!pkt_vlan_tagged || pkt_vid == `SFE_NULL_VID)
            eff_vid = in_port_default_vlan;
        else
            eff_vid = pkt_vid;
    end

    // Snooping trap classification
    reg mld_nh;
    reg mld_opt_nh;
    reg trap_nxt;
    always @*
    begin
        mld_nh = (pkt_next_hdr == `SFE_NH_ICMP) || (pkt_next_hdr == `SFE_NH_ICMP6) ||
            ((pkt_next_hdr == `SFE_NH_HBH) && ((pkt_hbh_next_hdr == `SFE_NH_ICMP) ||
            (pkt_hbh_next_hdr == `SFE_NH_ICMP6)));
        mld_opt_nh = 1'b0;
        for (j = 0; j < 2; j = j + 1)
        begin
            if (j == 0 || pkt_next_hdr == `SFE_NH_HBH)
            begin
                if ((j == 0 ? pkt_next_hdr : pkt_hbh_next_hdr) == `SFE_NH_ROUTE ||
                    (j == 0 ? pkt_next_hdr : pkt_hbh_next_hdr) == `SFE_NH_FRAG ||
                    (j == 0 ? pkt_next_hdr : pkt_hbh_next_hdr) == `SFE_NH_ESP ||
                    (j == 0 ? pkt_next_hdr : pkt_hbh_next_hdr) == `SFE_NH_AH ||
                    (j == 0 ? pkt_next_hdr : pkt_hbh_next_hdr) == `SFE_NH_DEST)
                    mld_opt_nh = 1'b1;
            end
        end
        trap_nxt = (igmp_snoop_en && pkt_is_ipv4 && pkt_ip_ver == `SFE_IP_VER4 &&
            pkt_ip_proto == `SFE_IP_PROTO_IGMP) ||
            (mld_snoop_en && pkt_is_ipv6_mcast && pkt_hop_limit == `SFE_MLD_HOP &&
            (mld_nh || (mld_option && mld_opt_nh)));
    end

    // Associative VLAN table search on the captured VID
    reg vt_hit;
    reg [6:0] vt_fid;
    reg [4:0] vt_mem;
    always @*
    begin
        vt_hit = 1'b0;
        vt_fid = 7'h00;
        vt_mem = 5'h00;
        for (k = 0; k < VT_ENTRIES; k = k + 1)
        begin
            if (vt_valid_r[k] && vt_vid_r[k] == vid_r && !vt_hit)
            begin
                vt_hit = 1'b1;
                vt_fid = vt_fid_r[k];
                vt_mem = vt_mem_r[k];
            end
        end
    end

    // Forwarding decision once MAC lookup answers
    reg [4:0] dyn_mask;
    reg [4:0] dest;
    reg direct;
    reg legal_nib;
    reg drop;
    reg [4:0] mirror;
    reg rx_m;
    reg tx_m;
    always @*
    begin
        dyn_mask = 5'h00;
        if (lk_dyn_port < NPORT)
            dyn_mask[lk_dyn_port] = 1'b1;
        legal_nib = (tag_r[3:0] == 4'h1) || (tag_r[3:0] == 4'h2) || (tag_r[3:0] == 4'h4) ||
            (tag_r[3:0] == 4'h8) || (tag_r[3:0] == `SFE_ALL_NET);
        direct = tag_mode_r && !tag_r[`SFE_TAG_NORMAL_BIT];
        drop = bad_r || (!vlan_ok_r && !(direct && tag_r[`SFE_TAG_FORCE_BIT]));
        if (direct)
            dest = legal_nib ? {1'b0, tag_r[3:0]} : 5'h00;
        else if (trap_r)
            dest = `SFE_HOST_MASK;
        else if (lk_static_hit && (!lk_static_use_fid || lk_static_filter_id == lk_filter_id))
            dest = lk_static_ports;
        else if (lk_dyn_hit)
            dest = dyn_mask;
        else
            dest = members_r;
        dest = drop ? 5'h00 : (dest & ~ing_mask_r);
        rx_m = |(rx_sniff & ing_mask_r) && (!bad_r || sniff_bad_en);
        tx_m = |(dest & tx_sniff);
        if (mirror_and)
            mirror = (rx_m && tx_m) ? sniffer_port : 5'h00;
        else
            mirror = (rx_m || tx_m) ? sniffer_port : 5'h00;
        if (!rx_m && bad_r)
            mirror = 5'h00;
    end

    // Sequencer and output registers
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_r <= S_IDLE;
            pkt_ready <= 1'b1;
            lk_req <= 1'b0;
            lk_filter_id <= 7'h00;
            fwd_valid <= 1'b0;
            fwd_ports <= 5'h00;
            fwd_queue_set <= 1'b0;
            fwd_queue <= 2'b00;
            fwd_strip_tag <= 1'b0;
            fwd_insert_tag <= 1'b0;
            fwd_host_tag <= 8'h00;
            learn_insert <= 1'b0;
            learn_refresh <= 1'b0;
            learn_filter_id <= 7'h00;
            port_r <= 3'h0;
            bad_r <= 1'b0;
            tag_r <= 8'h00;
            vid_r <= 12'h000;
            port_default_vlan_r <= 12'h000;
            trap_r <= 1'b0;
            tag_mode_r <= 1'b0;
            vlan_ok_r <= 1'b0;
            members_r <= 5'h00;
            ing_mask_r <= 5'h00;
        end
        else
        begin
            fwd_valid <= 1'b0;
            learn_insert <= 1'b0;
            learn_refresh <= 1'b0;
            lk_req <= 1'b0;
            case (state_r)
                S_IDLE:
                begin
                    if (pkt_valid)
                    begin
                        port_r <= pkt_port;
                        bad_r <= pkt_bad;
                        tag_r <= pkt_tail_tag;
                        vid_r <= eff_vid;
                        port_default_vlan_r <= in_port_default_vlan;
                        trap_r <= trap_nxt;
                        tag_mode_r <= tail_tag_en && pkt_port == `SFE_HOST_IDX;
                        ing_mask_r <= 5'h01 << pkt_port;
                        pkt_ready <= 1'b0;
                        state_r <= S_VLAN;
                    end
                end
                S_VLAN:
                begin
                    if (vlan_en)
                    begin
                        vlan_ok_r <= vt_hit && !(|(ingress_filter_en & ing_mask_r) &&
                            !(|(vt_mem & ing_mask_r))) &&
                            !(|(discard_non_port_default_vlan & ing_mask_r) && vid_r != port_default_vlan_r);
                        lk_filter_id <= vt_fid;
                        members_r <= vt_mem;
                    end
                    else
                    begin
                        vlan_ok_r <= 1'b1;
                        lk_filter_id <= 7'h00;
                        members_r <= 5'h1f;
                    end
                    lk_req <= 1'b1;
                    state_r <= S_WAIT;
                end
                S_WAIT:
                begin
                    if (lk_ack)
                    begin
                        fwd_valid <= 1'b1;
                        fwd_ports <= dest | mirror;
                        fwd_queue_set <= direct && !drop;
                        fwd_queue <= tag_r[`SFE_TAG_QUEUE_MSB:`SFE_TAG_QUEUE_LSB];
                        fwd_strip_tag <= tag_mode_r;
                        fwd_insert_tag <= tail_tag_en && port_r != `SFE_HOST_IDX &&
                            (dest[`SFE_HOST_IDX] | mirror[`SFE_HOST_IDX]);
                        fwd_host_tag <= {6'h00, port_r[1:0]};
                        learn_insert <= vlan_ok_r && !bad_r && !lk_sa_hit;
                        learn_refresh <= vlan_ok_r && !bad_r && lk_sa_hit;
                        learn_filter_id <= lk_filter_id;
                        pkt_ready <= 1'b1;
                        state_r <= S_IDLE;
                    end
                end
                default:
                begin
                    state_r <= S_IDLE;
                    pkt_ready <= 1'b1;
                end
            endcase
        end
    end

endmodule // sfe_engine

// >>> sfe_lk_model.sv
// Partner model of the MAC tables answering each lookup request
`timescale 1ns/100ps
module sfe_lk_model (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Request, scripted answer and its delay in cycles
    input wire lk_req,
    input wire [3:0] dly,
    input wire [18:0] ans,
    // Acknowledge and packed result
    output reg lk_ack,
    output reg [18:0] lk_res
);
    reg [3:0] cnt_r;
    // Count down to the ack; result lines toggle while not valid
    always @(posedge clk)
    begin
        lk_ack <= rst_n && cnt_r == 4'h1;
        lk_res <= !rst_n ? 19'h00000 : (cnt_r == 4'h1) ? ans : ~lk_res;
        if (!rst_n)
            cnt_r <= 4'h0;
        else if (lk_req)
            cnt_r <= dly;
        else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
    end
endmodule // sfe_lk_model

// >>> sfe_engine_monitor.sv
// Concurrent checks on the forwarding engine ports
`timescale 1ns/100ps
module sfe_monitor (
    // Clock, reset and configuration
    input wire clk,
    input wire rst_n,
    input wire tail_tag_en,
    input wire [4:0] sniffer_port,
    // Descriptor and lookup handshake
    input wire pkt_valid,
    input wire [2:0] pkt_port,
    input wire pkt_ready,
    input wire lk_req,
    input wire lk_ack,
    // Result and learning
    input wire fwd_valid,
    input wire [4:0] fwd_ports,
    input wire fwd_strip_tag,
    input wire fwd_insert_tag,
    input wire [7:0] fwd_host_tag,
    input wire learn_insert,
    input wire learn_refresh
);
    reg [2:0] in_r;
    // Ingress port of the packet in flight
    always @(posedge clk)
    begin
        if (!rst_n)
            in_r <= 3'h0;
        else if (pkt_valid && pkt_ready)
            in_r <= pkt_port;
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    chk_take_busy: assert property (pkt_valid && pkt_ready |=> !pkt_ready [*3])
        else $error("ready not dropped");
    chk_req_delay: assert property (pkt_valid && pkt_ready |-> ##2 lk_req)
        else $error("lookup request late");
    chk_ack_result: assert property (lk_req ##[1:15] lk_ack |=> fwd_valid && pkt_ready)
        else $error("no result after ack");
    chk_strip_flag: assert property (fwd_valid |->
        fwd_strip_tag == (tail_tag_en && in_r == 3'h4))
        else $error("strip flag wrong");
    chk_insert_flag: assert property (fwd_valid |->
        fwd_insert_tag == (tail_tag_en && in_r != 3'h4 && fwd_ports[4]))
        else $error("insert flag wrong");
    chk_host_tag: assert property (fwd_valid && fwd_insert_tag |->
        fwd_host_tag == {6'h00, in_r[1:0]})
        else $error("host tag wrong");
    chk_no_echo: assert property (fwd_valid && !sniffer_port[in_r] |-> !fwd_ports[in_r])
        else $error("sent back to ingress");
    chk_learn_once: assert property (learn_insert || learn_refresh |->
        fwd_valid && !(learn_insert && learn_refresh))
        else $error("learn pulse misplaced");
    cover property (fwd_valid && fwd_insert_tag);
    cover property (fwd_valid && fwd_strip_tag);
    cover property (learn_refresh);
endmodule // sfe_monitor
bind sfe_engine sfe_monitor sfe_monitor_inst (.clk, .rst_n, .tail_tag_en, .sniffer_port,
    .pkt_valid, .pkt_port, .pkt_ready, .lk_req, .lk_ack, .fwd_valid, .fwd_ports,
    .fwd_strip_tag, .fwd_insert_tag, .fwd_host_tag, .learn_insert, .learn_refresh);

// >>> test_switch_forwarding_engine.sv
// Self-checking bench of the switch forwarding engine
`timescale 1ns/100ps
module test_switch_forwarding_engine;
    localparam [23:0] nibs = 24'h0f8421;
    localparam [55:0] nhs = 56'h3c33322c2b3a01;
    reg clk = 1'b0, rst_n = 1'b0, pv = 1'b0, vwe = 1'b0, vval = 1'b0;
    reg pb = 1'b0, tg = 1'b0, v4 = 1'b0, v6m = 1'b0;
    reg [6:0] cfg = 7'h40, vidx = 7'h00, vfid = 7'h00;
    reg [4:0] rxs = 5'h00, txs = 5'h00, snf = 5'h00, ifl = 5'h00, dnp = 5'h00, vmem = 5'h00;
    reg [11:0] vvid = 12'h000, vid = 12'h000;
    reg [7:0] tag = 8'h00, proto = 8'h00, hop = 8'h01, nh = 8'h00, hnh = 8'h00, c;
    reg [2:0] pp = 3'h0;
    reg [3:0] dly = 4'h1;
    reg [3:0] ipv = 4'h4;
    reg [18:0] ans = 19'h00000;
    wire rdy, req, ack, fv, qs, st, it, li, lr;
    wire [6:0] filter_id, lf;
    wire [4:0] fp;
    wire [1:0] q;
    wire [7:0] ht;
    wire [18:0] res;
    integer n_fail = 0, checked = 0, i;
    sfe_engine sfe_engine_inst (
        .clk(clk), .rst_n(rst_n), .tail_tag_en(cfg[6]), .igmp_snoop_en(cfg[5]),
        .mld_snoop_en(cfg[4]), .mld_option(cfg[3]), .vlan_en(cfg[2]), .mirror_and(cfg[1]),
        .sniff_bad_en(cfg[0]), .rx_sniff(rxs), .tx_sniff(txs), .sniffer_port(snf),
        .ingress_filter_en(ifl), .discard_non_port_default_vlan(dnp), .port_default_vlan({5{12'h005}}),
        .vt_wr_en(vwe), .vt_wr_idx(vidx), .vt_wr_valid(vval), .vt_wr_vid(vvid),
        .vt_wr_filter_id(vfid), .vt_wr_members(vmem), .pkt_valid(pv), .pkt_port(pp),
        .pkt_bad(pb), .pkt_tail_tag(tag), .pkt_vlan_tagged(tg), .pkt_vid(vid),
        .pkt_is_ipv4(v4), .pkt_ip_ver(ipv), .pkt_ip_proto(proto), .pkt_is_ipv6_mcast(v6m),
        .pkt_hop_limit(hop), .pkt_next_hdr(nh), .pkt_hbh_next_hdr(hnh), .pkt_ready(rdy),
        .lk_req(req), .lk_filter_id(filter_id), .lk_ack(ack), .lk_static_hit(res[18]),
        .lk_static_use_fid(res[17]), .lk_static_filter_id(res[16:10]),
        .lk_static_ports(res[9:5]), .lk_dyn_hit(res[4]), .lk_dyn_port(res[3:1]),
        .lk_sa_hit(res[0]), .fwd_valid(fv), .fwd_ports(fp), .fwd_queue_set(qs),
        .fwd_queue(q), .fwd_strip_tag(st), .fwd_insert_tag(it), .fwd_host_tag(ht),
        .learn_insert(li), .learn_refresh(lr), .learn_filter_id(lf));
    sfe_lk_model sfe_lk_model_inst (.clk(clk), .rst_n(rst_n), .lk_req(req), .dly(dly),
        .ans(ans), .lk_ack(ack), .lk_res(res));
    // 25 MHz clock
    always #20 clk = ~clk;
    // Lookup answer with a dynamic hit on port p
    function [18:0] dh(input [2:0] p);
        dh = {14'h0000, 1'b1, p, 1'b0};
    endfunction
    task cmp(input [11:0] got, input [11:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            n_fail = n_fail + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // One descriptor, then wait for its result
    task send(input [4:0] e);
        integer k;
    begin
        @(posedge clk) pv <= 1'b1;
        @(posedge clk) pv <= 1'b0;
        #1;
        for (k = 0; k < 40 && fv !== 1'b1; k = k + 1)
            @(posedge clk) #1;
        cmp({fv, fp}, {1'b1, e});
    end
    endtask
    task vtw(input [31:0] e);
    begin
        @(posedge clk) {vwe, vidx, vval, vvid, vfid, vmem} <= {1'b1, e};
        @(posedge clk) vwe <= 1'b0;
    end
    endtask
    task mrow(input [6:0] m, input [4:0] r, input [4:0] t, input b, input [2:0] d, input [4:0] e);
    begin
        @(posedge clk) {cfg, rxs, txs, pb, ans} <= {m, r, t, b, dh(d)};
        send(e);
    end
    endtask
    task stop_test;
    begin
        $display("Comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    end
    endtask
    // Watchdog against a hung handshake
    initial
    begin
        #100000;
        n_fail = n_fail + 1;
        stop_test;
    end
    // Main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 6; i = i + 1)
        begin
            @(posedge clk) {pp, tag} <= {3'h4, 1'b0, i[0], i[1:0], nibs[i*4 +: 4]};
            send({1'b0, nibs[i*4 +: 4]});
            cmp({qs, q, st, it}, {1'b1, i[1:0], 2'b10});
        end
        @(posedge clk) {tag, dly, ans} <= {8'h81, 4'h3, dh(3'h2)};
        send(5'h04);
        cmp({qs, st}, 2'b01);
        for (i = 0; i < 4; i = i + 1)
        begin
            @(posedge clk) {pp, ans} <= {i[2:0], 18'h00000, i[0]};
            send(5'h1f & ~(5'h01 << i));
            cmp({it, ht, li, lr}, {1'b1, 6'h00, i[1:0], ~i[0], i[0]});
        end
        @(posedge clk) {cfg, pp, ans, v4, proto} <= {7'h60, 3'h0, 19'h00000, 1'b1, 8'h02};
        send(5'h10);
        @(posedge clk) proto <= 8'h03;
        send(5'h1e);
        // IGMP protocol number under a non-IPv4 version must not trap
        @(posedge clk) {proto, ipv} <= {8'h02, 4'h6};
        send(5'h1e);
        for (i = 0; i < 14; i = i + 1)
        begin
            c = nhs[(i / 2) * 8 +: 8];
            @(posedge clk) {cfg, v4, v6m, hnh, nh} <= {3'h5, i[0], 5'h01, c, i[0] ? 8'h00 : c};
            send((i < 4 || i[0]) ? 5'h10 : 5'h1e);
        end
        @(posedge clk) hop <= 8'h02;
        send(5'h1e);
        @(posedge clk) {snf, v6m} <= {5'h08, 1'b0};
        mrow(7'h40, 5'h01, 5'h00, 1'b0, 3'h1, 5'h0a);
        mrow(7'h40, 5'h00, 5'h04, 1'b0, 3'h2, 5'h0c);
        mrow(7'h42, 5'h01, 5'h04, 1'b0, 3'h1, 5'h02);
        mrow(7'h42, 5'h01, 5'h04, 1'b0, 3'h2, 5'h0c);
        mrow(7'h40, 5'h01, 5'h00, 1'b1, 3'h1, 5'h00);
        mrow(7'h41, 5'h01, 5'h00, 1'b1, 3'h1, 5'h08);
        vtw({7'h02, 1'b1, 12'h005, 7'h09, 5'h07});
        vtw({7'h03, 1'b0, 12'h006, 7'h0a, 5'h1f});
        vtw({7'h04, 1'b1, 12'h007, 7'h0b, 5'h1e});
        @(posedge clk) {cfg, pb, rxs, txs, snf, ans} <= {7'h44, 16'h0000, 19'h00000};
        send(5'h06);
        cmp({filter_id, lf, li}, {7'h09, 7'h09, 1'b1});
        @(posedge clk) tg <= 1'b1;
        send(5'h06);
        @(posedge clk) ans <= {2'b10, 7'h05, 5'h18, 5'h00};
        send(5'h18);
        @(posedge clk) ans <= {2'b11, 7'h09, 5'h18, 5'h00};
        send(5'h18);
        @(posedge clk) ans <= {2'b11, 7'h05, 5'h18, 1'b1, 3'h3, 1'b0};
        send(5'h08);
        @(posedge clk) ans <= {2'b11, 7'h05, 5'h18, 5'h00};
        send(5'h06);
        @(posedge clk) {vid, ans} <= {12'h006, 19'h00000};
        send(5'h00);
        cmp({li, lr}, 2'b00);
        @(posedge clk) {vid, dnp} <= {12'h007, 5'h01};
        send(5'h00);
        @(posedge clk) dnp <= 5'h00;
        send(5'h1e);
        @(posedge clk) ifl <= 5'h01;
        send(5'h00);
        // Forced host frame passes an invalid VID; without the force it is dropped
        @(posedge clk) {cfg, ifl, pp, tag, vid} <= {7'h44, 5'h00, 3'h4, 8'h41, 12'h006};
        send(5'h01);
        @(posedge clk) tag <= 8'h01;
        send(5'h00);
        cmp(qs, 1'b0);
        @(posedge clk) {cfg, ifl, pp, tag} <= {7'h00, 5'h00, 3'h4, 8'h01};
        send(5'h0f);
        stop_test;
    end
endmodule // test_switch_forwarding_engine
